/* File: inc/parity_unit_regs.svh */
// register map, field layout and reset values of the port parity error unit
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`ifndef PARITY_UNIT_REGS_SVH
`define PARITY_UNIT_REGS_SVH

`define ADDR_W 12
`define DATA_W 32
`define LANES 4

// register byte addresses
`define OFF_CHK_CTL 12'h4D4
`define OFF_ERR_STS 12'h4D8
`define OFF_RPT_CTL 12'h4DC
`define OFF_ERR_CNT 12'h4E0
`define OFF_IRQ_MASK 12'h4F0

// field positions
`define CHK_DISABLE_BIT 0
`define CHK_INJECT_BIT 1
`define CHK_LEN_LSB 8
`define CHK_LEN_MSB 15
`define STS_PARITY_BIT 0
`define RPT_CODE_LSB 0
`define RPT_CODE_MSB 1
`define RPT_IRQ_BIT 2
`define CNT_LSB 0
`define CNT_MSB 7
`define HDR_LEN_LSB 0
`define HDR_LEN_MSB 7

// reset values and constants
`define RPT_CODE_RST 2'h2
`define RPT_CODE_NONE 2'h0
`define CNT_MAX 8'hFF
`define CNT_ONE 8'h01
`define CNT_ZERO 8'h00
`define WORD_ZERO 32'h00000000
`define PAR_ZERO 4'h0
`define PAR_ALL 4'hF

`endif

/* File: inc/parity_unit_pkg.sv */
// types shared by the port parity error unit
`default_nettype none
`include "parity_unit_regs.svh"

package parity_unit_pkg;

	typedef logic [`DATA_W-1:0] word_t;
	typedef logic [`LANES-1:0] par_t;
	typedef logic [`ADDR_W-1:0] addr_t;
	typedef logic [`CNT_MSB:`CNT_LSB] cnt_t;
	typedef logic [`RPT_CODE_MSB:`RPT_CODE_LSB] rpt_t;
	typedef logic [`CHK_LEN_MSB-`CHK_LEN_LSB:0] len_t;

	// which source owns the path to the switch core
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LINK,
		ST_LOCAL
	} path_t;

	typedef struct packed {
		// sticky fields
		logic chk_disable;
		logic chk_inject;
		len_t chk_len;
		cnt_t cnt;
		// non-sticky fields
		logic status;
		rpt_t rpt;
		logic rpt_irq;
		logic mask;
		path_t fsm;
		logic qual;
		// outputs
		logic out_valid;
		word_t out_data;
		par_t out_par;
		logic out_sof;
		logic out_eof;
		logic in_ready;
		logic gen_ready;
		logic msg_valid;
		rpt_t msg_type;
		logic intmsi;
		logic irq;
		logic pready;
		word_t prdata;
		logic pslverr;
	} state_t;

endpackage

`default_nettype wire

/* File: core/parity_unit.sv */
// port end-to-end parity check, generation, injection and error reporting
`timescale 1ns/1ps
`default_nettype none
`include "parity_unit_regs.svh"

module parity_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic port_rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire parity_unit_pkg::addr_t paddr,
	input wire parity_unit_pkg::word_t pwdata,
	output logic pready,
	output parity_unit_pkg::word_t prdata,
	output logic pslverr,
	// words from the ingress link
	input wire logic in_valid,
	input wire parity_unit_pkg::word_t in_data,
	input wire parity_unit_pkg::par_t in_par,
	input wire logic in_sof,
	input wire logic in_eof,
	output logic in_ready,
	// words of TLPs the port makes itself
	input wire logic gen_valid,
	input wire parity_unit_pkg::word_t gen_data,
	input wire logic gen_sof,
	input wire logic gen_eof,
	output logic gen_ready,
	// words toward the switch core
	output logic out_valid,
	output parity_unit_pkg::word_t out_data,
	output parity_unit_pkg::par_t out_par,
	output logic out_sof,
	output logic out_eof,
	// error reporting
	input wire logic upstream_irq_en,
	output logic msg_valid,
	output parity_unit_pkg::rpt_t msg_type,
	output logic intmsi_req,
	output logic irq
);
	import parity_unit_pkg::*;

	state_t s_q;
	state_t s_d;
	par_t in_calc;
	par_t gen_calc;
	par_t out_calc;
	logic in_take;
	logic gen_take;
	logic wr_fire;
	logic rd_fire;
	logic cnt_rd;
	logic err;
	logic match;

	// ---------------------------------------------------------------
	// per-byte even parity
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `LANES; g++) begin : g_lane
			assign in_calc[g] = ^in_data[g*8 +: 8];
			assign gen_calc[g] = ^gen_data[g*8 +: 8];
			assign out_calc[g] = ^s_q.out_data[g*8 +: 8];
		end
	endgenerate

	// handshakes and apb access edges; writes and reads act in the access cycle
	assign in_take = in_valid & s_q.in_ready;
	assign gen_take = gen_valid & s_q.gen_ready;
	assign wr_fire = psel & penable & pwrite & s_q.pready;
	assign rd_fire = psel & penable & ~pwrite & s_q.pready;
	assign cnt_rd = rd_fire & (paddr == `OFF_ERR_CNT);

	// checking is gated off entirely by the disable bit
	assign err = in_take & ~s_q.chk_disable & (in_par != in_calc);

	// header byte zero compared on the first word of a TLP
	assign match = in_take ? (in_data[`HDR_LEN_MSB:`HDR_LEN_LSB] == s_q.chk_len)
		: (gen_data[`HDR_LEN_MSB:`HDR_LEN_LSB] == s_q.chk_len);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic sof;
		logic corrupt;
		cnt_t cnt_base;
		sof = 1'b0;
		corrupt = 1'b0;
		cnt_base = s_q.cnt;
		s_d = s_q;

		// path to the switch core: link words win, local words wait for a gap
		s_d.out_valid = in_take | gen_take;
		if (in_take) begin
			s_d.out_data = in_data;
			s_d.out_par = in_calc;
			s_d.out_sof = in_sof;
			s_d.out_eof = in_eof;
			sof = in_sof;
		end else if (gen_take) begin
			s_d.out_data = gen_data;
			s_d.out_par = gen_calc;
			s_d.out_sof = gen_sof;
			s_d.out_eof = gen_eof;
			sof = gen_sof;
		end else begin
			s_d.out_sof = 1'b0;
			s_d.out_eof = 1'b0;
		end

		// qualify on the header word and keep it for the rest of the TLP
		if ((in_take | gen_take) & sof) begin
			s_d.qual = match;
		end
		corrupt = s_q.chk_inject & (sof ? match : s_q.qual);
		if ((in_take | gen_take) & corrupt) begin
			s_d.out_par = s_d.out_par ^ `PAR_ALL;
		end

		// ownership of the output path
		unique case (s_q.fsm)
			ST_IDLE: begin
				if (in_take & in_sof & ~in_eof) begin
					s_d.fsm = ST_LINK;
				end else if (~in_valid & gen_valid & gen_sof) begin
					s_d.fsm = ST_LOCAL;
				end
			end
			ST_LINK: begin
				if (in_take & in_eof) begin
					s_d.fsm = ST_IDLE;
				end
			end
			ST_LOCAL: begin
				if (gen_take & gen_eof) begin
					s_d.fsm = ST_IDLE;
				end
			end
		endcase

		// status flag: a new error beats a write-one clear in the same cycle
		if (wr_fire & (paddr == `OFF_ERR_STS) & pwdata[`STS_PARITY_BIT]) begin
			s_d.status = 1'b0;
		end
		if (err) begin
			s_d.status = 1'b1;
		end

		// counter: the read clears, an error in that same cycle still counts
		if (cnt_rd) begin
			cnt_base = `CNT_ZERO;
		end
		if (err & (cnt_base != `CNT_MAX)) begin
			cnt_base = cnt_base + `CNT_ONE;
		end
		s_d.cnt = cnt_base;

		// control register writes; reserved bits are dropped
		if (wr_fire) begin
			unique case (paddr)
				`OFF_CHK_CTL: begin
					s_d.chk_disable = pwdata[`CHK_DISABLE_BIT];
					s_d.chk_inject = pwdata[`CHK_INJECT_BIT];
					s_d.chk_len = pwdata[`CHK_LEN_MSB:`CHK_LEN_LSB];
				end
				`OFF_RPT_CTL: begin
					s_d.rpt = pwdata[`RPT_CODE_MSB:`RPT_CODE_LSB];
					s_d.rpt_irq = pwdata[`RPT_IRQ_BIT];
				end
				`OFF_IRQ_MASK: begin
					s_d.mask = pwdata[`STS_PARITY_BIT];
				end
				default: begin
				end
			endcase
		end

		// port reset spares the sticky fields (checker, counter)
		if (~port_rst_n) begin
			s_d.status = 1'b0;
			s_d.rpt = `RPT_CODE_RST;
			s_d.rpt_irq = 1'b0;
			s_d.mask = 1'b0;
			s_d.fsm = ST_IDLE;
			s_d.qual = 1'b0;
			s_d.out_valid = 1'b0;
		end

		// reports fire on the stored flag's rising edge only
		s_d.msg_valid = ~s_q.status & s_d.status & (s_q.rpt != `RPT_CODE_NONE);
		s_d.msg_type = s_q.rpt;
		s_d.intmsi = ~s_q.status & s_d.status & s_q.rpt_irq & upstream_irq_en;
		s_d.irq = s_d.status & s_d.mask;

		// ready flags follow the next owner so the sources see them in the same cycle as the owner register
		s_d.in_ready = (s_d.fsm != ST_LOCAL);
		s_d.gen_ready = (s_d.fsm == ST_LOCAL);

		// apb: answer in the first access cycle, read data fetched at setup
		s_d.pready = psel & ~penable;
		s_d.pslverr = 1'b0;
		s_d.prdata = `WORD_ZERO;
		if (psel & ~penable) begin
			unique case (paddr)
				`OFF_CHK_CTL: begin
					s_d.prdata[`CHK_DISABLE_BIT] = s_q.chk_disable;
					s_d.prdata[`CHK_INJECT_BIT] = s_q.chk_inject;
					s_d.prdata[`CHK_LEN_MSB:`CHK_LEN_LSB] = s_q.chk_len;
				end
				`OFF_ERR_STS: begin
					s_d.prdata[`STS_PARITY_BIT] = s_q.status;
				end
				`OFF_RPT_CTL: begin
					s_d.prdata[`RPT_CODE_MSB:`RPT_CODE_LSB] = s_q.rpt;
					s_d.prdata[`RPT_IRQ_BIT] = s_q.rpt_irq;
				end
				`OFF_ERR_CNT: begin
					// value shown is from setup and includes an error in setup; one in the access cycle is kept
					s_d.prdata[`CNT_MSB:`CNT_LSB] = s_d.cnt;
				end
				`OFF_IRQ_MASK: begin
					s_d.prdata[`STS_PARITY_BIT] = s_q.mask;
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// state register; full device reset initialises everything
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.rpt <= `RPT_CODE_RST;
			s_q.fsm <= ST_IDLE;
			s_q.in_ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign pready = s_q.pready;
	assign prdata = s_q.prdata;
	assign pslverr = s_q.pslverr;
	assign in_ready = s_q.in_ready;
	assign gen_ready = s_q.gen_ready;
	assign out_valid = s_q.out_valid;
	assign out_data = s_q.out_data;
	assign out_par = s_q.out_par;
	assign out_sof = s_q.out_sof;
	assign out_eof = s_q.out_eof;
	assign msg_valid = s_q.msg_valid;
	assign msg_type = s_q.msg_type;
	assign intmsi_req = s_q.intmsi;
	assign irq = s_q.irq;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence seq_flag_held;
		s_q.status ##1 s_q.status;
	endsequence

	sequence seq_new_error;
		!s_q.status && err && port_rst_n;
	endsequence

	AST_NO_FLAG_WHEN_OFF: assert property (
		(s_q.chk_disable && !s_q.status) |=> !s_q.status)
		else $error("parity flag set while checking disabled");

	AST_PARITY_GOOD: assert property (
		(in_take && !s_q.chk_inject && port_rst_n) |=> (s_q.out_valid && s_q.out_par == out_calc))
		else $error("forwarded word carries wrong parity");

	AST_INJECT_HDR: assert property (
		(in_take && in_sof && s_q.chk_inject && match && port_rst_n)
		|=> (s_q.out_par == (out_calc ^ `PAR_ALL)))
		else $error("qualifying header word not corrupted");

	AST_NO_INJECT_MISMATCH: assert property (
		(in_take && in_sof && !match && port_rst_n) |=> (s_q.out_par == out_calc))
		else $error("non-matching TLP corrupted");

	AST_FLAG_SET: assert property (
		(err && port_rst_n) |=> s_q.status)
		else $error("detected error did not set flag");

	AST_REPORT_ONCE: assert property (
		seq_flag_held |-> (!s_q.msg_valid && !s_q.intmsi))
		else $error("report repeated while flag stays set");

	AST_REPORT_CODE: assert property (
		(seq_new_error and (s_q.rpt != `RPT_CODE_NONE))
		|=> (s_q.msg_valid && s_q.msg_type == $past(s_q.rpt)))
		else $error("error message missing or wrong type");

	AST_INTMSI: assert property (
		seq_new_error |=> (s_q.intmsi == $past(s_q.rpt_irq && upstream_irq_en)))
		else $error("interrupt request does not follow enables");

	AST_CNT_SAT: assert property (
		(s_q.cnt == `CNT_MAX && !cnt_rd) |=> (s_q.cnt == `CNT_MAX))
		else $error("error counter wrapped");

	AST_CNT_CLEAR: assert property (
		(cnt_rd && !err) |=> (s_q.cnt == `CNT_ZERO))
		else $error("counter not cleared by read");

	AST_RSVD_ZERO: assert property (
		s_q.pready |-> (s_q.prdata[`DATA_W-1:`CHK_LEN_MSB+1] == '0))
		else $error("reserved bits read nonzero");

	// a disabled checker must leave the tally alone, not only the flag
	AST_NO_COUNT_WHEN_OFF: assert property (
		(s_q.chk_disable && !cnt_rd) |=> (s_q.cnt == $past(s_q.cnt)))
		else $error("error counter moved while checking disabled");

	// body words inherit the header's verdict, even when their byte zero differs
	AST_INJECT_BODY: assert property (
		(gen_take && !gen_sof && s_q.qual && s_q.chk_inject && port_rst_n)
		|=> (s_q.out_par == (out_calc ^ `PAR_ALL)))
		else $error("body word of qualifying TLP not corrupted");

	// local words that do not qualify leave with freshly computed parity
	AST_GEN_PARITY: assert property (
		(gen_take && port_rst_n && !(s_q.chk_inject && (gen_sof ? match : s_q.qual)))
		|=> (s_q.out_valid && s_q.out_par == out_calc))
		else $error("local word carries wrong parity");

endmodule

`default_nettype wire

/* File: tb/link_model.sv */
// ingress link source model sending single-word TLPs
`timescale 1ns/1ps
`default_nettype none
module link_model (
	input wire logic pclk,
	input wire logic in_ready,
	output var logic in_valid,
	output var parity_unit_pkg::word_t in_data,
	output var parity_unit_pkg::par_t in_par,
	output var logic in_sof,
	output var logic in_eof
);
	import parity_unit_pkg::*;
	// even parity of each byte lane
	function automatic par_t bpar(input word_t w);
		par_t p;
		for (int i = 0; i < 4; i++) begin
			p[i] = ^w[8*i +: 8];
		end
		return p;
	endfunction
	initial begin
		in_valid = 1'h0;
		in_data = 32'h0;
		in_par = 4'h0;
		in_sof = 1'h0;
		in_eof = 1'h0;
	end
	// hold the word until taken; after release the lines no longer show it
	task automatic send(input word_t d, input logic bad);
		@(posedge pclk);
		in_valid <= 1'h1;
		in_sof <= 1'h1;
		in_eof <= 1'h1;
		in_data <= d;
		in_par <= bpar(d) ^ {4{bad}};
		do @(posedge pclk); while (in_ready !== 1'h1);
		in_valid <= 1'h0;
		in_sof <= 1'h0;
		in_eof <= 1'h0;
		in_data <= ~d;
		in_par <= ~in_par;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the port parity error unit
`timescale 1ns/1ps
`default_nettype none
`include "parity_unit_regs.svh"
module tb;
	import parity_unit_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, port_rst_n = 1'h1, irq_en = 1'h0;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, slverr;
	addr_t paddr = 12'h0;
	word_t pwdata = 32'h0, prdata, out_data, last_dat, v, in_data;
	par_t out_par, last_par, in_par;
	logic in_valid, in_sof, in_eof, in_ready, out_valid, msg_valid, intmsi, irq;
	logic gen_valid = 1'h0, gen_sof = 1'h0, gen_eof = 1'h0, gen_ready, out_sof, out_eof;
	logic [1:0] last_se;
	word_t gen_data = 32'h0;
	rpt_t msg_type, last_type;
	int n_fail = 0, total_checks = 0, n_msg = 0, n_int = 0, m, k;
	word_t dat [3] = '{32'h1234565A, 32'hA5C30F5A, 32'hA5C30F5B};
	word_t ctl [3] = '{32'h00000001, 32'h00005A02, 32'h00005A02};
	word_t gdat [4] = '{32'h0000005A, 32'h12345678, 32'h00000011, 32'h0000005A};
	always #20 pclk = ~pclk;
	parity_unit dut_u (.pclk(pclk), .presetn(presetn), .port_rst_n(port_rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .in_valid(in_valid),
		.in_data(in_data), .in_par(in_par), .in_sof(in_sof), .in_eof(in_eof),
		.in_ready(in_ready), .gen_valid(gen_valid), .gen_data(gen_data), .gen_sof(gen_sof),
		.gen_eof(gen_eof), .gen_ready(gen_ready), .out_valid(out_valid), .out_data(out_data),
		.out_par(out_par), .out_sof(out_sof), .out_eof(out_eof), .upstream_irq_en(irq_en),
		.msg_valid(msg_valid), .msg_type(msg_type), .intmsi_req(intmsi), .irq(irq));
	link_model link_u (.pclk(pclk), .in_ready(in_ready), .in_valid(in_valid),
		.in_data(in_data), .in_par(in_par), .in_sof(in_sof), .in_eof(in_eof));
	// ----------------------------------------
	// monitors and shared tasks
	// ----------------------------------------
	// pulses are one cycle wide, so they are counted on every edge
	always @(posedge pclk) begin
		if (out_valid === 1'h1) begin
			last_par <= out_par;
			last_dat <= out_data;
			last_se <= {out_sof, out_eof};
		end
		if (msg_valid === 1'h1) begin
			n_msg <= n_msg + 1;
			last_type <= msg_type;
		end
		if (intmsi === 1'h1) n_int <= n_int + 1;
	end
	task automatic check(input string nm, input word_t seen, input word_t exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// apb transfer held until pready is sampled high
	task automatic apb(input logic wr, input addr_t a, input word_t wd, output word_t rd);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		slverr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic err(input word_t d, input logic bad);
		link_u.send(d, bad);
		repeat (4) @(posedge pclk);
	endtask
	// local source: hold each word until the port grants it the path
	task automatic gen_send(input word_t d, input logic s, input logic e);
		@(posedge pclk);
		gen_valid <= 1'h1;
		gen_data <= d;
		gen_sof <= s;
		gen_eof <= e;
		do @(posedge pclk); while (gen_ready !== 1'h1);
		gen_valid <= 1'h0;
		gen_sof <= 1'h0;
		gen_eof <= 1'h0;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		complete_run;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		apb(0, `OFF_CHK_CTL, 0, v); check("chk_ctl", v, 32'h0);
		apb(0, `OFF_RPT_CTL, 0, v); check("rpt_ctl", v, 32'h2);
		apb(0, 12'h4E4, 0, v); check("unmapped", {v[30:0], slverr}, 32'h1);
		apb(1, `OFF_CHK_CTL, 32'hFFFFFFFF, v);
		apb(0, `OFF_CHK_CTL, 0, v); check("reserved", v, 32'h0000FF03);
		apb(1, `OFF_CHK_CTL, 0, v);
		$display("test registers done");
		apb(1, `OFF_IRQ_MASK, 1, v);
		apb(1, `OFF_RPT_CTL, 32'h6, v);
		irq_en <= 1'h1;
		err(32'h11, 1);
		err(32'h22, 1);
		check("msgs", n_msg, 1);
		check("type", last_type, 2);
		check("intmsi", n_int, 1);
		check("irq", irq, 1);
		apb(0, `OFF_ERR_STS, 0, v); check("sts", v, 32'h1);
		apb(0, `OFF_ERR_CNT, 0, v); check("cnt", v, 32'h2);
		apb(0, `OFF_ERR_CNT, 0, v); check("cnt_clr", v, 32'h0);
		apb(1, `OFF_ERR_STS, 1, v);
		apb(0, `OFF_ERR_STS, 0, v); check("sts_clr", v, 32'h0);
		check("irq_clr", irq, 0);
		$display("test detect done");
		// every report code; the interrupt request needs both enables at once
		for (int c = 0; c < 4; c++) begin
			apb(1, `OFF_RPT_CTL, ((c != 1) ? 32'h4 : 32'h0) | c, v);
			irq_en <= c[0];
			m = n_msg;
			k = n_int;
			err(32'h33, 1);
			check("msg_cnt", n_msg - m, c != 0);
			if (c != 0) check("msg_type", last_type, c);
			check("int_cnt", n_int - k, c == 3);
			apb(1, `OFF_ERR_STS, 1, v);
		end
		apb(0, `OFF_ERR_CNT, 0, v);
		$display("test codes done");
		apb(1, `OFF_CHK_CTL, 1, v);
		m = n_msg;
		err(32'h44, 1);
		apb(0, `OFF_ERR_STS, 0, v); check("dis_sts", v, 32'h0);
		apb(0, `OFF_ERR_CNT, 0, v); check("dis_cnt", v, 32'h0);
		check("dis_msg", n_msg - m, 0);
		$display("test disable done");
		// generation with checks off, injection on match, none on mismatch
		for (int i = 0; i < 3; i++) begin
			apb(1, `OFF_CHK_CTL, ctl[i], v);
			err(dat[i], 0);
			check("out_dat", last_dat, dat[i]);
			check("out_par", last_par, link_u.bpar(dat[i]) ^ {4{i == 1}});
		end
		$display("test generate done");
		// local two-word TLPs: the header word decides for the whole TLP
		apb(1, `OFF_CHK_CTL, 32'h00005A02, v);
		for (int j = 0; j < 4; j++) begin
			gen_send(gdat[j], j % 2 == 0, j % 2 == 1);
			repeat (2) @(posedge pclk);
			check("gen_dat", last_dat, gdat[j]);
			check("gen_par", last_par, link_u.bpar(gdat[j]) ^ {4{j < 2}});
			check("gen_se", last_se, {j % 2 == 0, j % 2 == 1});
		end
		$display("test local done");
		apb(1, `OFF_CHK_CTL, 0, v);
		repeat (258) err(32'h55, 1);
		apb(1, `OFF_CHK_CTL, 32'h00005A02, v);
		@(posedge pclk);
		port_rst_n <= 1'h0;
		@(posedge pclk);
		port_rst_n <= 1'h1;
		apb(0, `OFF_ERR_STS, 0, v); check("prst_sts", v, 32'h0);
		apb(0, `OFF_CHK_CTL, 0, v); check("prst_ctl", v, 32'h00005A02);
		apb(0, `OFF_RPT_CTL, 0, v); check("prst_rpt", v, 32'h2);
		apb(0, `OFF_ERR_CNT, 0, v); check("sat_cnt", v, 32'hFF);
		$display("test saturate done");
		complete_run;
	end
endmodule
`default_nettype wire
